// ---- hdl/wsu_pkg.sv ----
// Purpose: shared constants of the word shift unit
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes: offsets are byte addresses
package wsu_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int WORD_W = 16;
  localparam int CNT_W = 5;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [ADDR_W-1:0] OFF_SER_WORD = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_SER_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_OPERAND = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_WCTRL = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h14;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int SER_LEVEL_BIT = 0;
  localparam int SER_SHIFT_BIT = 1;
  localparam int SER_CLEAR_BIT = 2;
  localparam int WC_ENABLE_BIT = 0;
  localparam int WC_LEFT_BIT = 1;
  localparam int WC_EXEC_BIT = 2;
  localparam int ST_CARRY_BIT = 0;
  localparam int ST_ENABLE_BIT = 1;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [WORD_W-1:0] RST_WORD = 16'h0000;
  localparam logic [CNT_W-1:0] RST_COUNT = 5'h00;
  localparam logic RST_BIT = 1'b0;

endpackage

// ---- hdl/wsu_barrel.sv ----
// Purpose: combinational word shifter with carry of last bit out
// Assumes: count 0 means no shift and no carry update
// Notes: counts above the word width give zero and carry zero
`timescale 1ns/10ps
module wsu_barrel #(
  parameter int WIDTH = 16,
  parameter int CW = 5
) (
  // operand
  input wire logic [WIDTH-1:0] din,
  input wire logic [CW-1:0] count,
  input wire logic left,
  // result
  output logic [WIDTH-1:0] dout,
  output logic carry_valid,
  output logic carry_out
);

  int n;

  always_comb begin
    n = int'(count);
    dout = din;
    carry_valid = 1'b0;
    carry_out = 1'b0;
    if (n == 0) begin
      dout = din;
    end else if (n <= WIDTH) begin
      carry_valid = 1'b1;
      if (left) begin
        dout = din << count;
        carry_out = din[WIDTH-n];
      end else begin
        dout = din >> count;
        carry_out = din[n-1];
      end
    end else begin
      carry_valid = 1'b1;
      dout = '0;
      carry_out = 1'b0;
    end
  end

endmodule

// ---- hdl/wsu_serial_shifter.sv ----
// Purpose: one-bit left shift register with serial input
// Assumes: strobes are one-cycle pulses on the same clock
// Notes: clear beats shift, shift beats a software load
`timescale 1ns/10ps
module wsu_serial_shifter #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // control
  input wire logic serial_in_level,
  input wire logic shift_strobe,
  input wire logic clear_strobe,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_data,
  // state
  output logic [WIDTH-1:0] word
);

  logic [WIDTH-1:0] next_word;

  always_comb begin
    next_word = word;
    if (clear_strobe) begin
      next_word = '0;
    end else if (shift_strobe) begin
      next_word = {word[WIDTH-2:0], serial_in_level};
    end else if (load) begin
      next_word = load_data;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      word <= RESET_VALUE;
    end else begin
      word <= next_word;
    end
  end

endmodule

// ---- hdl/wsu_top.sv ----
// Purpose: shift datapath with serial shifter and word shifts on APB
// Assumes: 20 MHz clock, zero-wait APB slave, synchronous reset
// Notes: word shifts run only on an execute write while enabled
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/10ps

// How it works
// - shift strobe moves word one bit up
// - serial level feeds bit 0 on shift
// - clear strobe zeroes the serial word
// - right shift moves operand down by count
// - word shifts act only while enabled
// - right shift copies last bit out to carry
// - right shift zero-fills the top count bits
// - left shift moves operand up by count
// - left shift carries last bit, zero-fills bottom
module wsu_top #(
  parameter int WIDTH = wsu_pkg::WORD_W,
  parameter int CW = wsu_pkg::CNT_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wsu_pkg::ADDR_W-1:0] paddr,
  input wire logic [wsu_pkg::DATA_W-1:0] pwdata,
  output logic [wsu_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // datapath state
  output logic [WIDTH-1:0] serial_word,
  output logic [WIDTH-1:0] operand_word,
  output logic carry_relay
);
  import wsu_pkg::*;

  // ************************************************************
  // elaboration checks
  // ************************************************************
  generate
    if (WIDTH < 2 || WIDTH > DATA_W) begin : g_bad_width
      $error("word width out of range");
    end
    if ((1 << CW) <= WIDTH) begin : g_bad_count
      $error("count field too narrow for word width");
    end
    if (CW < 1 || CW > DATA_W) begin : g_bad_cw
      $error("count width out of range");
    end
    if (SER_CLEAR_BIT >= DATA_W || WC_EXEC_BIT >= DATA_W) begin : g_bad_bit
      $error("control field beyond data width");
    end
    if (ADDR_W < 5) begin : g_bad_addr
      $error("address too narrow for register map");
    end
  endgenerate

  // ************************************************************
  // apb decode
  // ************************************************************
  logic setup_phase;
  logic access_phase;
  logic wr_access;
  logic addr_hit;

  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign wr_access = access_phase && pwrite;
  assign pready = access_phase;

  // ************************************************************
  // write selects
  // ************************************************************
  logic wr_ser_word;
  logic wr_operand;

  assign wr_ser_word = wr_access && paddr == OFF_SER_WORD;
  assign wr_operand = wr_access && paddr == OFF_OPERAND;

  always_comb begin
    case (paddr)
      OFF_SER_WORD,
      OFF_SER_CTRL,
      OFF_OPERAND,
      OFF_COUNT,
      OFF_WCTRL,
      OFF_STATUS: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  // ************************************************************
  // software state
  // ************************************************************
  logic serial_in_level;
  logic shift_strobe;
  logic clear_strobe;
  logic ser_load;
  logic [CW-1:0] shift_count;
  logic word_enable;
  logic word_left;
  logic exec_pulse;
  logic next_serial_in_level;
  logic next_shift_strobe;
  logic next_clear_strobe;
  logic next_ser_load;
  logic [CW-1:0] next_shift_count;
  logic next_word_enable;
  logic next_word_left;
  logic next_exec_pulse;
  logic [WIDTH-1:0] load_data;

  assign load_data = pwdata[WIDTH-1:0];

  // strobes last one cycle after the write edge
  always_comb begin
    next_serial_in_level = serial_in_level;
    next_shift_strobe = 1'b0;
    next_clear_strobe = 1'b0;
    next_ser_load = 1'b0;
    next_shift_count = shift_count;
    next_word_enable = word_enable;
    next_word_left = word_left;
    next_exec_pulse = 1'b0;
    if (wr_access) begin
      case (paddr)
        OFF_SER_WORD: begin
          next_ser_load = 1'b1;
        end
        OFF_SER_CTRL: begin
          next_serial_in_level = pwdata[SER_LEVEL_BIT];
          next_shift_strobe = pwdata[SER_SHIFT_BIT];
          next_clear_strobe = pwdata[SER_CLEAR_BIT];
        end
        OFF_COUNT: begin
          next_shift_count = pwdata[CW-1:0];
        end
        OFF_WCTRL: begin
          next_word_enable = pwdata[WC_ENABLE_BIT];
          next_word_left = pwdata[WC_LEFT_BIT];
          next_exec_pulse = pwdata[WC_EXEC_BIT];
        end
        default: begin
          next_ser_load = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      serial_in_level <= RST_BIT;
      shift_strobe <= RST_BIT;
      clear_strobe <= RST_BIT;
      ser_load <= RST_BIT;
      shift_count <= RST_COUNT;
      word_enable <= RST_BIT;
      word_left <= RST_BIT;
      exec_pulse <= RST_BIT;
    end else begin
      serial_in_level <= next_serial_in_level;
      shift_strobe <= next_shift_strobe;
      clear_strobe <= next_clear_strobe;
      ser_load <= next_ser_load;
      shift_count <= next_shift_count;
      word_enable <= next_word_enable;
      word_left <= next_word_left;
      exec_pulse <= next_exec_pulse;
    end
  end

  // ************************************************************
  // serial left shifter
  // ************************************************************
  logic [WIDTH-1:0] ser_load_data;
  logic [WIDTH-1:0] next_ser_load_data;

  always_comb begin
    next_ser_load_data = ser_load_data;
    if (wr_ser_word) begin
      next_ser_load_data = load_data;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ser_load_data <= RST_WORD;
    end else begin
      ser_load_data <= next_ser_load_data;
    end
  end

  // strobes arrive one edge after the write, with its level
  wsu_serial_shifter #(
    .WIDTH(WIDTH),
    .RESET_VALUE(RST_WORD)
  ) u_serial (
    .clock(clock),
    .sys_rst(sys_rst),
    .serial_in_level(serial_in_level),
    .shift_strobe(shift_strobe),
    .clear_strobe(clear_strobe),
    .load(ser_load),
    .load_data(ser_load_data),
    .word(serial_word)
  );

  // ************************************************************
  // word shifter
  // ************************************************************
  logic [WIDTH-1:0] shifted;
  logic carry_valid;
  logic carry_out;
  logic [WIDTH-1:0] next_operand_word;
  logic next_carry_relay;

  // carry moves only when bits leave the word
  wsu_barrel #(
    .WIDTH(WIDTH),
    .CW(CW)
  ) u_barrel (
    .din(operand_word),
    .count(shift_count),
    .left(word_left),
    .dout(shifted),
    .carry_valid(carry_valid),
    .carry_out(carry_out)
  );

  // execution wins over an operand write in the same cycle
  always_comb begin
    next_operand_word = operand_word;
    next_carry_relay = carry_relay;
    if (exec_pulse && word_enable) begin
      next_operand_word = shifted;
      if (carry_valid) begin
        next_carry_relay = carry_out;
      end
    end else if (wr_operand) begin
      next_operand_word = load_data;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      operand_word <= RST_WORD;
      carry_relay <= RST_BIT;
    end else begin
      operand_word <= next_operand_word;
      carry_relay <= next_carry_relay;
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  logic [DATA_W-1:0] rd_value;
  logic [DATA_W-1:0] next_prdata;
  logic next_pslverr;

  always_comb begin
    rd_value = '0;
    case (paddr)
      OFF_SER_WORD: rd_value[WIDTH-1:0] = serial_word;
      OFF_SER_CTRL: rd_value[SER_LEVEL_BIT] = serial_in_level;
      OFF_OPERAND: rd_value[WIDTH-1:0] = operand_word;
      OFF_COUNT: rd_value[CW-1:0] = shift_count;
      OFF_WCTRL: begin
        rd_value[WC_ENABLE_BIT] = word_enable;
        rd_value[WC_LEFT_BIT] = word_left;
      end
      OFF_STATUS: begin
        rd_value[ST_CARRY_BIT] = carry_relay;
        rd_value[ST_ENABLE_BIT] = word_enable;
      end
      default: rd_value = '0;
    endcase
  end

  // answer captured at the setup edge, held through access
  always_comb begin
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (setup_phase) begin
      next_prdata = pwrite ? '0 : rd_value;
      next_pslverr = !addr_hit;
    end else if (!psel) begin
      next_prdata = '0;
      next_pslverr = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prdata <= '0;
      pslverr <= RST_BIT;
    end else begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

endmodule

// ---- sim/wsu_properties.sv ----
// Purpose: timing checks of the word shift unit at its ports
// Assumes: zero-wait APB, strobes act one edge after the write edge
// Notes: shift count is tracked from COUNT writes
`timescale 1ns/10ps
module wsu_properties #(
  parameter int WIDTH = 16,
  parameter int CW = 5
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wsu_pkg::ADDR_W-1:0] paddr,
  input wire logic [wsu_pkg::DATA_W-1:0] pwdata,
  // state
  input wire logic [WIDTH-1:0] serial_word,
  input wire logic [WIDTH-1:0] operand_word,
  input wire logic carry_relay
);
  import wsu_pkg::*;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] next_cnt;
  logic wr;
  logic sc;
  logic ex;
  logic rs;
  logic ls;
  assign wr = psel && penable && pwrite;
  assign sc = wr && paddr == OFF_SER_CTRL;
  assign ex = wr && paddr == OFF_WCTRL && pwdata[WC_EXEC_BIT];
  assign rs = ex && pwdata[WC_ENABLE_BIT] && !pwdata[WC_LEFT_BIT]
    && cnt_q != 0 && cnt_q <= WIDTH;
  assign ls = ex && pwdata[WC_ENABLE_BIT] && pwdata[WC_LEFT_BIT]
    && cnt_q != 0 && cnt_q <= WIDTH;
  // ****
  // count copy
  // ****
  always_comb begin
    next_cnt = cnt_q;
    if (wr && paddr == OFF_COUNT) begin
      next_cnt = pwdata[CW-1:0];
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt_q <= RST_COUNT;
    end else begin
      cnt_q <= next_cnt;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ****
  // checks
  // ****
  shift_up_a: assert property (sc && pwdata[SER_SHIFT_BIT] &&
    !pwdata[SER_CLEAR_BIT] |-> ##2
    serial_word[WIDTH-1:1] == $past(serial_word[WIDTH-2:0]))
    else $error("serial shift lost bits");
  shift_in_a: assert property (sc && pwdata[SER_SHIFT_BIT] &&
    !pwdata[SER_CLEAR_BIT] |-> ##2
    serial_word[0] == $past(pwdata[SER_LEVEL_BIT], 2))
    else $error("serial input bit wrong");
  ser_clear_a: assert property (sc && pwdata[SER_CLEAR_BIT]
    |-> ##2 serial_word == '0) else $error("serial word not cleared");
  hold_off_a: assert property (ex && !pwdata[WC_ENABLE_BIT]
    |-> ##2 $stable(operand_word) && $stable(carry_relay))
    else $error("disabled shift changed state");
  right_shift_a: assert property (rs |-> ##2
    operand_word == $past(operand_word) >> cnt_q)
    else $error("right shift result wrong");
  right_carry_a: assert property (rs |-> ##2
    carry_relay == $past(operand_word[cnt_q-1]))
    else $error("right shift carry wrong");
  left_shift_a: assert property (ls |-> ##2
    operand_word == $past(operand_word) << cnt_q)
    else $error("left shift result wrong");
  left_carry_a: assert property (ls |-> ##2
    carry_relay == $past(operand_word[WIDTH-cnt_q]))
    else $error("left shift carry wrong");
  cover property (sc && pwdata[SER_SHIFT_BIT] && pwdata[SER_CLEAR_BIT]);
  cover property (rs);
  cover property (ls);
  cover property (ex && !pwdata[WC_ENABLE_BIT]);
endmodule

// ---- sim/testbench.sv ----
// Purpose: register level tests of the word shift unit
// Assumes: zero-wait APB slave, one idle cycle between transfers
// Notes: expectations are worked out here from the shift rules
`timescale 1ns/10ps
module testbench;
  import wsu_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic [WORD_W-1:0] serial_word;
  logic [WORD_W-1:0] operand_word;
  logic carry_relay;
  logic [DATA_W-1:0] q;
  logic e;
  logic [WORD_W-1:0] d = 16'hb5a3;
  logic [WORD_W-1:0] ex;
  logic c;
  int n_fail = 0;
  int check_count = 0;
  int ns[4] = '{1, 4, 15, 16};
  int n;
  int k;
  always #25 clock = ~clock;
  wsu_top i_wsu_top (.clock, .sys_rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .serial_word,
    .operand_word, .carry_relay);
  // ****
  // tasks
  // ****
  task apb(input logic w, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd,
    output logic err);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk(input string nm, input logic [31:0] xp, input logic [31:0] got);
    check_count++;
    if (got !== xp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, xp, got);
    end
  endtask
  task settle;
    repeat (2) @(negedge clock);
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ****
  // tests
  // ****
  initial begin
    repeat (3000) @(posedge clock);
    n_fail++;
    wrap_up;
  end
  initial begin
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    for (k = 0; k < 6; k++) begin
      apb(1'b0, 8'(k * 4), '0, q, e);
      chk("reset read", '0, q);
    end
    apb(1'b1, OFF_SER_WORD, 32'h8001, q, e);
    apb(1'b1, OFF_SER_CTRL, 32'h3, q, e);
    settle;
    chk("serial one", 32'h3, 32'(serial_word));
    apb(1'b1, OFF_SER_CTRL, 32'h2, q, e);
    apb(1'b0, OFF_SER_WORD, '0, q, e);
    chk("serial zero", 32'h6, q);
    apb(1'b1, OFF_SER_CTRL, 32'h6, q, e);
    settle;
    chk("clear and shift", '0, 32'(serial_word));
    apb(1'b1, OFF_SER_WORD, 32'hffff, q, e);
    apb(1'b0, OFF_SER_WORD, '0, q, e);
    chk("serial load", 32'hffff, q);
    apb(1'b1, OFF_SER_CTRL, 32'h5, q, e);
    settle;
    chk("clear", '0, 32'(serial_word));
    for (k = 0; k < 8; k++) begin
      n = ns[k / 2];
      apb(1'b1, OFF_OPERAND, 32'(d), q, e);
      apb(1'b1, OFF_COUNT, 32'(n), q, e);
      apb(1'b1, OFF_WCTRL, 32'(5 + 2 * (k % 2)), q, e);
      ex = (k % 2 == 1) ? d << n : d >> n;
      c = (k % 2 == 1) ? d[16 - n] : d[n - 1];
      apb(1'b0, OFF_STATUS, '0, q, e);
      chk("status", {30'h0, 1'b1, c}, q);
      chk("result", 32'(ex), 32'(operand_word));
      chk("carry", 32'(c), 32'(carry_relay));
    end
    apb(1'b1, OFF_OPERAND, 32'h00f0, q, e);
    apb(1'b1, OFF_WCTRL, 32'h6, q, e);
    apb(1'b0, OFF_STATUS, '0, q, e);
    chk("held status", 32'h1, q);
    chk("held operand", 32'h00f0, 32'(operand_word));
    apb(1'b1, OFF_COUNT, 32'h0, q, e);
    apb(1'b1, OFF_WCTRL, 32'h5, q, e);
    apb(1'b0, OFF_STATUS, '0, q, e);
    chk("zero count status", 32'h3, q);
    chk("zero count operand", 32'h00f0, 32'(operand_word));
    apb(1'b1, OFF_COUNT, 32'h14, q, e);
    apb(1'b0, OFF_COUNT, '0, q, e);
    chk("count", 32'h14, q);
    apb(1'b1, OFF_WCTRL, 32'h7, q, e);
    apb(1'b0, OFF_STATUS, '0, q, e);
    chk("long count status", 32'h2, q);
    chk("long count operand", '0, 32'(operand_word));
    apb(1'b1, 8'h3c, 32'h1234, q, e);
    apb(1'b0, 8'h3c, '0, q, e);
    chk("unmapped err", 32'h1, 32'(e));
    chk("unmapped data", '0, q);
    wrap_up;
  end
endmodule
bind wsu_top wsu_properties #(.WIDTH(WIDTH), .CW(CW)) i_wsu_properties (
  .clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .serial_word, .operand_word, .carry_relay);
